// [common/amr_pkg.sv]
// constants for the converter monitor, reference and pin control block
package amr_pkg;
  // register addresses
  localparam logic [7:0] PRIMARY_STATUS_ADDR = 8'h01;
  localparam logic [7:0] MODE_REG_THREE_ADDR = 8'h02;
  localparam logic [7:0] REF_CFG_ADDR = 8'h03;
  localparam logic [7:0] FILTER_CFG_ADDR = 8'h04;
  localparam logic [7:0] PIN_DIR_ADDR = 8'h05;
  localparam logic [7:0] PGA_ALARM_STATUS_ADDR = 8'h11;
  localparam logic [7:0] SECONDARY_STATUS_ADDR = 8'h12;
  // field positions
  localparam int SUMMARY_BIT = 4;
  localparam int REF_LOW_BIT = 3;
  localparam int CRC_BIT = 0;
  localparam int REF_NEG_LSB = 0;
  localparam int REF_POS_LSB = 2;
  localparam int REF_EN_BIT = 4;
  localparam int PIN_DAT_LSB = 0;
  localparam int PIN_CON_LSB = 4;
  localparam int FILT_ORDER_LSB = 0;
  localparam int FILT_MODE_BIT = 3;
  localparam int NUM_PINS = 4;
  localparam int NUM_ALARMS = 8;
  // reference select codes
  localparam logic [1:0] REF_SEL_INTERNAL = 2'h0;
  localparam logic [1:0] REF_SEL_SUPPLY = 2'h1;
  localparam logic [1:0] REF_SEL_EXT_A = 2'h2;
  localparam logic [1:0] REF_SEL_EXT_B = 2'h3;
  // reset values
  localparam logic [7:0] REF_CFG_RESET = 8'h05;
  localparam logic [7:0] FILTER_CFG_RESET = 8'h04;
  localparam logic [3:0] PIN_DIR_RESET = 4'hF;
  // modulator rate divider
  localparam int MOD_DIV = 8;
  localparam logic [2:0] MOD_DIV_LAST = 3'(MOD_DIV - 1);
  // filter modes and order bounds
  typedef enum logic [1:0] {
    FILT_SINC = 2'b01,
    FILT_COEF = 2'b10
  } amr_filt_mode_t;
  localparam logic [2:0] ORDER_MIN = 3'h1;
  localparam logic [2:0] ORDER_MAX = 3'h5;
endpackage

// [logic/amr_ctrl.sv]
// control and status register bank for the converter monitor block
// How it works
// - eight overload alarm inputs, four points each with low and high alarm
// - each overload alarm has its own bit in the alarm status register
// - summary flag at bit 4 is OR of overload flags and checksum error
// - overload flags latch and stay set after the condition goes away
// - reading the alarm status register clears the latched overload bits
// - summary flag drops only when overload and checksum flags are both clear
// - select code 00 picks the on-chip reference for each path
// - code 10 picks external pair a, code 11 picks external pair b
// - both reference selects reset to 01, supply and ground
// - on-chip reference enable bit resets to disabled
// - low-reference alarm at bit 3 while reference is below 0.4 V
// - low-reference alarm is read-only, clears at first conversion after fault
// - four pin data bits in mode register three, readable and writable
// - each pin function connects to its pin only while its connect bit is 1
// - direction bit 1 makes a pin input, 0 makes it output
// - reading an output pin returns the written value, not the pin level
// - two pins shared with external reference pair b, two dedicated
// - modulator runs at master clock divided by 8 giving a bit stream
// - sinc mode offers orders one to five, rates 2.5 SPS to 40 kSPS
// - coefficient mode gives single-cycle settled data at 2.5 to 20 SPS
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module amr_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] pga_alarm_i,
  input wire logic crc_error_i,
  input wire logic crc_error_clear_i,
  input wire logic ref_below_min_i,
  input wire logic conv_done_i,
  input wire logic [3:0] pin_in_i,
  output logic [3:0] pin_out_o,
  output logic [3:0] pin_oe_o,
  output logic [1:0] ref_pos_select_o,
  output logic [1:0] ref_neg_select_o,
  output logic [3:0] ref_route_pos_o,
  output logic [3:0] ref_route_neg_o,
  output logic int_ref_enable_o,
  output logic ext_ref_b_claimed_o,
  output logic mod_clk_en_o,
  output logic [1:0] filter_mode_o,
  output logic [2:0] filter_order_o,
  output logic pga_crc_summary_flag_o,
  output logic ref_low_alarm_o
);

  // ******************************
  // decode helpers
  // ******************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // one-hot reference route: bit0 internal, bit1 supply, bit2 ext a, bit3 ext b
  function automatic logic [3:0] ref_route(input logic [1:0] sel);
    case (sel)
      amr_pkg::REF_SEL_INTERNAL: ref_route = 4'h1;
      amr_pkg::REF_SEL_SUPPLY: ref_route = 4'h2;
      amr_pkg::REF_SEL_EXT_A: ref_route = 4'h4;
      default: ref_route = 4'h8;
    endcase
  endfunction

  function automatic logic [2:0] clamp_order(input logic [2:0] o);
    if (o < amr_pkg::ORDER_MIN) begin
      clamp_order = amr_pkg::ORDER_MIN;
    end else if (o > amr_pkg::ORDER_MAX) begin
      clamp_order = amr_pkg::ORDER_MAX;
    end else begin
      clamp_order = o;
    end
  endfunction

  logic wr_ref, wr_mode_reg_three, wr_filt, wr_dir, rd_alarm;
  assign wr_ref = wr_i && hit(addr_i, amr_pkg::REF_CFG_ADDR);
  assign wr_mode_reg_three = wr_i && hit(addr_i, amr_pkg::MODE_REG_THREE_ADDR);
  assign wr_filt = wr_i && hit(addr_i, amr_pkg::FILTER_CFG_ADDR);
  assign wr_dir = wr_i && hit(addr_i, amr_pkg::PIN_DIR_ADDR);
  assign rd_alarm = rd_i && hit(addr_i, amr_pkg::PGA_ALARM_STATUS_ADDR);

  // ******************************
  // overload alarms and summary
  // ******************************
  logic [7:0] alarm_q;
  logic crc_q;
  logic ref_low_q;

  genvar g;
  generate
    for (g = 0; g < amr_pkg::NUM_ALARMS; g++) begin : g_alarm
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          alarm_q[g] <= 1'b0;
        end else if (pga_alarm_i[g]) begin
          alarm_q[g] <= 1'b1;
        end else if (rd_alarm) begin
          alarm_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // checksum error flag, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      crc_q <= 1'b0;
    end else if (crc_error_i) begin
      crc_q <= 1'b1;
    end else if (crc_error_clear_i) begin
      crc_q <= 1'b0;
    end
  end

  logic summary_d;
  assign summary_d = (|alarm_q) | crc_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pga_crc_summary_flag_o <= 1'b0;
    end else begin
      pga_crc_summary_flag_o <= summary_d;
    end
  end

  // ******************************
  // reference monitor
  // ******************************
  // set while reference low
  // clears at conversion after fault ends
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ref_low_q <= 1'b0;
    end else if (ref_below_min_i) begin
      ref_low_q <= 1'b1;
    end else if (conv_done_i) begin
      ref_low_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ref_low_alarm_o <= 1'b0;
    end else begin
      ref_low_alarm_o <= ref_low_q;
    end
  end

  // ******************************
  // reference configuration
  // ******************************
  logic [1:0] ref_pos_q, ref_neg_q;
  logic ref_en_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ref_pos_q <= amr_pkg::REF_CFG_RESET[amr_pkg::REF_POS_LSB +: 2];
      ref_neg_q <= amr_pkg::REF_CFG_RESET[amr_pkg::REF_NEG_LSB +: 2];
      ref_en_q <= amr_pkg::REF_CFG_RESET[amr_pkg::REF_EN_BIT];
    end else if (wr_ref) begin
      ref_pos_q <= wdata_i[amr_pkg::REF_POS_LSB +: 2];
      ref_neg_q <= wdata_i[amr_pkg::REF_NEG_LSB +: 2];
      ref_en_q <= wdata_i[amr_pkg::REF_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ref_pos_select_o <= amr_pkg::REF_SEL_SUPPLY;
      ref_neg_select_o <= amr_pkg::REF_SEL_SUPPLY;
      ref_route_pos_o <= ref_route(amr_pkg::REF_SEL_SUPPLY);
      ref_route_neg_o <= ref_route(amr_pkg::REF_SEL_SUPPLY);
      int_ref_enable_o <= 1'b0;
    end else begin
      ref_pos_select_o <= ref_pos_q;
      ref_neg_select_o <= ref_neg_q;
      ref_route_pos_o <= ref_route(ref_pos_q);
      ref_route_neg_o <= ref_route(ref_neg_q);
      int_ref_enable_o <= ref_en_q;
    end
  end

  // ******************************
  // general-purpose pins
  // ******************************
  logic [3:0] pin_dat_q, pin_con_q, pin_dir_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_dat_q <= 4'h0;
      pin_con_q <= 4'h0;
    end else if (wr_mode_reg_three) begin
      pin_dat_q <= wdata_i[amr_pkg::PIN_DAT_LSB +: amr_pkg::NUM_PINS];
      pin_con_q <= wdata_i[amr_pkg::PIN_CON_LSB +: amr_pkg::NUM_PINS];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_dir_q <= amr_pkg::PIN_DIR_RESET;
    end else if (wr_dir) begin
      pin_dir_q <= wdata_i[amr_pkg::NUM_PINS-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_out_o <= 4'h0;
      pin_oe_o <= 4'h0;
    end else begin
      pin_out_o <= pin_dat_q;
      pin_oe_o <= pin_con_q & ~pin_dir_q;
    end
  end

  // pins 2 and 3 shared with reference pair b
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ext_ref_b_claimed_o <= 1'b0;
    end else begin
      ext_ref_b_claimed_o <= |pin_con_q[3:2];
    end
  end

  logic [3:0] pin_rd;
  // output pins read back the written value
  assign pin_rd = (pin_dir_q & pin_con_q & pin_in_i) | (~pin_dir_q & pin_dat_q);

  // ******************************
  // modulator rate and filter mode
  // ******************************
  logic [2:0] div_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_q <= 3'h0;
      mod_clk_en_o <= 1'b0;
    end else begin
      div_q <= (div_q == amr_pkg::MOD_DIV_LAST) ? 3'h0 : div_q + 3'h1;
      mod_clk_en_o <= (div_q == amr_pkg::MOD_DIV_LAST);
    end
  end

  logic filt_coef_q;
  logic [2:0] order_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      filt_coef_q <= amr_pkg::FILTER_CFG_RESET[amr_pkg::FILT_MODE_BIT];
      order_q <= amr_pkg::FILTER_CFG_RESET[amr_pkg::FILT_ORDER_LSB +: 3];
    end else if (wr_filt) begin
      filt_coef_q <= wdata_i[amr_pkg::FILT_MODE_BIT];
      order_q <= clamp_order(wdata_i[amr_pkg::FILT_ORDER_LSB +: 3]);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      filter_mode_o <= amr_pkg::FILT_SINC;
      filter_order_o <= amr_pkg::FILTER_CFG_RESET[amr_pkg::FILT_ORDER_LSB +: 3];
    end else begin
      filter_mode_o <= filt_coef_q ? amr_pkg::FILT_COEF : amr_pkg::FILT_SINC;
      filter_order_o <= order_q;
    end
  end

  // ******************************
  // register read port
  // ******************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr_i)
      amr_pkg::PRIMARY_STATUS_ADDR: begin
        rd_mux[amr_pkg::SUMMARY_BIT] = summary_d;
        rd_mux[amr_pkg::REF_LOW_BIT] = ref_low_q;
      end
      amr_pkg::PGA_ALARM_STATUS_ADDR: rd_mux = alarm_q;
      amr_pkg::SECONDARY_STATUS_ADDR: rd_mux[amr_pkg::CRC_BIT] = crc_q;
      amr_pkg::MODE_REG_THREE_ADDR: rd_mux = {pin_con_q, pin_rd};
      amr_pkg::REF_CFG_ADDR: rd_mux = {3'h0, ref_en_q, ref_pos_q, ref_neg_q};
      amr_pkg::FILTER_CFG_ADDR: rd_mux = {4'h0, filt_coef_q, order_q};
      amr_pkg::PIN_DIR_ADDR: rd_mux = {4'h0, pin_dir_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ******************************
  // checks
  // ******************************
  a_alarm_latch_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (|pga_alarm_i) && !rd_alarm |=> (alarm_q & $past(pga_alarm_i)) == $past(pga_alarm_i))
    else $error("alarm not latched");
  a_alarm_read_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_alarm && !(|pga_alarm_i) |=> alarm_q == 8'h00)
    else $error("alarm not cleared by read");
  a_alarm_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_alarm && (|pga_alarm_i) |=> (alarm_q & $past(pga_alarm_i)) == $past(pga_alarm_i))
    else $error("set lost to clear");
  a_summary_or: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ##1 pga_crc_summary_flag_o == $past(|alarm_q | crc_q))
    else $error("summary mismatch");
  a_summary_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    crc_q |=> pga_crc_summary_flag_o)
    else $error("summary dropped with checksum flag set");
  a_ref_low_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ref_low_q && !conv_done_i |=> ref_low_q)
    else $error("ref alarm cleared without conversion");
  a_ref_low_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ref_below_min_i |=> ##1 ref_low_alarm_o)
    else $error("ref alarm not raised");
  a_pin_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !pin_con_q[0] |=> !pin_oe_o[0])
    else $error("unconnected pin driven");
  a_pin_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_i && hit(addr_i, amr_pkg::MODE_REG_THREE_ADDR) && !pin_dir_q[1]
    |=> rdata_o[1] == $past(pin_dat_q[1]))
    else $error("output pin readback wrong");
  a_mod_rate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mod_clk_en_o |=> !mod_clk_en_o [*7] ##1 mod_clk_en_o)
    else $error("modulator rate not divide by eight");
  a_ref_route: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ref_pos_q == amr_pkg::REF_SEL_INTERNAL |=> ref_route_pos_o == 4'h1)
    else $error("internal reference not routed");
  a_ext_route: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ref_neg_q == amr_pkg::REF_SEL_EXT_B |=> ref_route_neg_o == 4'h8)
    else $error("reference pair b not routed");
  a_summary_drop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(|alarm_q) && !crc_q |=> !pga_crc_summary_flag_o)
    else $error("summary stuck with all flags clear");
  a_ref_low_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    conv_done_i && !ref_below_min_i |=> !ref_low_q)
    else $error("ref alarm not cleared by conversion");
  a_pin_input_dir: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pin_dir_q[2] |=> !pin_oe_o[2])
    else $error("input pin driven");
  a_pin_input_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_i && hit(addr_i, amr_pkg::MODE_REG_THREE_ADDR) && pin_dir_q[0] && pin_con_q[0]
    |=> rdata_o[0] == $past(pin_in_i[0]))
    else $error("input pin readback wrong");
  a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
endmodule

// [verif/amr_ctrl_bench.sv]
// self-checking testbench for the converter monitor register bank
`timescale 1ns/100ps
module amr_ctrl_bench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] pga_alarm_i = 8'h00;
  logic crc_error_i = 1'b0;
  logic crc_error_clear_i = 1'b0;
  logic ref_below_min_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [3:0] pin_in_i = 4'h0;
  logic [3:0] pin_out_o, pin_oe_o, ref_route_pos_o, ref_route_neg_o;
  logic [1:0] ref_pos_select_o, ref_neg_select_o, filter_mode_o;
  logic [2:0] filter_order_o;
  logic int_ref_enable_o, ext_ref_b_claimed_o, mod_clk_en_o;
  logic pga_crc_summary_flag_o, ref_low_alarm_o;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int checked = 0;
  integer seed = 32'h7C9220A2;

  amr_ctrl uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pga_alarm_i(pga_alarm_i),
    .crc_error_i(crc_error_i), .crc_error_clear_i(crc_error_clear_i),
    .ref_below_min_i(ref_below_min_i), .conv_done_i(conv_done_i), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .ref_pos_select_o(ref_pos_select_o),
    .ref_neg_select_o(ref_neg_select_o), .ref_route_pos_o(ref_route_pos_o),
    .ref_route_neg_o(ref_route_neg_o), .int_ref_enable_o(int_ref_enable_o),
    .ext_ref_b_claimed_o(ext_ref_b_claimed_o), .mod_clk_en_o(mod_clk_en_o),
    .filter_mode_o(filter_mode_o), .filter_order_o(filter_order_o),
    .pga_crc_summary_flag_o(pga_crc_summary_flag_o), .ref_low_alarm_o(ref_low_alarm_o));

  always #12.5 sys_clk_i = ~sys_clk_i;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // read data is noted here and compared by the monitor below
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  always @(posedge sys_clk_i) rd_pend <= rd_i;

  always @(negedge sys_clk_i) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        chk(rdata_o, 8'hXX);
      end else begin
        chk(rdata_o, exp_q.pop_front());
      end
    end
  end

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [7:0] a, d, p;
    int n;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle();
    chk(ref_pos_select_o, amr_pkg::REF_SEL_SUPPLY);
    chk(ref_neg_select_o, amr_pkg::REF_SEL_SUPPLY);
    chk(int_ref_enable_o, 1'b0);
    rd(amr_pkg::REF_CFG_ADDR, amr_pkg::REF_CFG_RESET);
    rd(amr_pkg::FILTER_CFG_ADDR, amr_pkg::FILTER_CFG_RESET);
    rd(amr_pkg::PIN_DIR_ADDR, {4'h0, amr_pkg::PIN_DIR_RESET});
    wr(8'h7E, 8'hA5);
    rd(8'h7E, 8'h00);
    done("reset");
    a = 8'($random(seed)) | 8'h01;
    @(posedge sys_clk_i);
    pga_alarm_i <= a;
    @(posedge sys_clk_i);
    pga_alarm_i <= 8'h00;
    settle();
    chk(pga_crc_summary_flag_o, 1'b1);
    rd(amr_pkg::PRIMARY_STATUS_ADDR, 8'h10);
    rd(amr_pkg::PGA_ALARM_STATUS_ADDR, a);
    rd(amr_pkg::PGA_ALARM_STATUS_ADDR, 8'h00);
    settle();
    chk(pga_crc_summary_flag_o, 1'b0);
    done("alarm");
    @(posedge sys_clk_i);
    crc_error_i <= 1'b1;
    pga_alarm_i <= 8'h80;
    @(posedge sys_clk_i);
    crc_error_i <= 1'b0;
    pga_alarm_i <= 8'h00;
    settle();
    rd(amr_pkg::PGA_ALARM_STATUS_ADDR, 8'h80);
    settle();
    chk(pga_crc_summary_flag_o, 1'b1);
    rd(amr_pkg::SECONDARY_STATUS_ADDR, 8'h01);
    @(posedge sys_clk_i);
    crc_error_clear_i <= 1'b1;
    @(posedge sys_clk_i);
    crc_error_clear_i <= 1'b0;
    settle();
    chk(pga_crc_summary_flag_o, 1'b0);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= amr_pkg::PGA_ALARM_STATUS_ADDR;
    pga_alarm_i <= 8'h40;
    exp_q.push_back(8'h00);
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    pga_alarm_i <= 8'h00;
    rd(amr_pkg::PGA_ALARM_STATUS_ADDR, 8'h40);
    done("checksum");
    @(posedge sys_clk_i);
    ref_below_min_i <= 1'b1;
    settle();
    chk(ref_low_alarm_o, 1'b1);
    wr(amr_pkg::PRIMARY_STATUS_ADDR, 8'h00);
    rd(amr_pkg::PRIMARY_STATUS_ADDR, 8'h08);
    ref_below_min_i <= 1'b0;
    settle();
    chk(ref_low_alarm_o, 1'b1);
    @(posedge sys_clk_i);
    conv_done_i <= 1'b1;
    @(posedge sys_clk_i);
    conv_done_i <= 1'b0;
    settle();
    chk(ref_low_alarm_o, 1'b0);
    done("reflow");
    for (int i = 0; i < 16; i++) begin
      d = {3'h0, 1'b1, 4'(i)};
      wr(amr_pkg::REF_CFG_ADDR, d);
      settle();
      chk(ref_pos_select_o, d[3:2]);
      chk(ref_neg_select_o, d[1:0]);
      chk(ref_route_pos_o, 4'h1 << d[3:2]);
      chk(ref_route_neg_o, 4'h1 << d[1:0]);
      chk(int_ref_enable_o, 1'b1);
      rd(amr_pkg::REF_CFG_ADDR, d);
    end
    done("refsel");
    d = 8'($random(seed));
    p = ~d;
    pin_in_i <= p[3:0];
    wr(amr_pkg::PIN_DIR_ADDR, 8'h03);
    wr(amr_pkg::MODE_REG_THREE_ADDR, {4'hF, d[3:0]});
    settle();
    chk(pin_oe_o, 4'hC);
    chk(pin_out_o[3:2], d[3:2]);
    chk(ext_ref_b_claimed_o, 1'b1);
    rd(amr_pkg::MODE_REG_THREE_ADDR, {4'hF, d[3:2], p[1:0]});
    wr(amr_pkg::MODE_REG_THREE_ADDR, {4'h3, d[3:0]});
    settle();
    chk(pin_oe_o, 4'h0);
    chk(ext_ref_b_claimed_o, 1'b0);
    wr(amr_pkg::PIN_DIR_ADDR, 8'h00);
    settle();
    chk(pin_oe_o, 4'h3);
    chk(pin_out_o[1:0], d[1:0]);
    rd(amr_pkg::MODE_REG_THREE_ADDR, {4'h3, d[3:0]});
    done("pins");
    // modulator rate
    // step off the edge so the enable is seen settled
    #1;
    n = 0;
    while (mod_clk_en_o !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (mod_clk_en_o !== 1'b1 && n < 20);
    chk(n[7:0], 8'(amr_pkg::MOD_DIV));
    done("modrate");
    for (int o = 0; o < 8; o++) begin
      wr(amr_pkg::FILTER_CFG_ADDR, {4'h0, 1'(o), 3'(o)});
      settle();
      chk(filter_order_o, (o < 1) ? 3'h1 : (o > 5) ? 3'h5 : 3'(o));
      chk(filter_mode_o, (o % 2) ? amr_pkg::FILT_COEF : amr_pkg::FILT_SINC);
    end
    done("filter");
    settle();
    print_verdict();
  end
endmodule
